// *** bench/sbt_ctl_model.sv ***
`timescale 1ns/1ns
module sbt_ctl_model
  import sbt_pkg::*;
(
  output sbt_jtag_in_t pins,
  input wire logic tdo
);
  initial pins = 3'h0;
  // One test clock period; tdo read just before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    pins.tms = ms;
    pins.tdi = di;
    #62 dout = tdo;
    pins.tck = 1'h1;
    #63 pins.tck = 1'h0;
    pins.tdi = ~di;
  endtask : step
endmodule : sbt_ctl_model

// *** bench/sbt_tap_assertions.sv ***
`timescale 1ns/1ns
module sbt_tap_checker
  import sbt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sbt_jtag_in_t jtag_in,
  input wire logic jtag_tms_present,
  input wire sbt_jtag_out_t jtag_out,
  input wire logic sram_outputs_hiz,
  input wire logic tap_in_reset
);
  logic [2:0] tck_s;
  logic [2:0] ones;
  wire tms_eff = jtag_in.tms | ~jtag_tms_present;
  wire tck_rise = tck_s[1] & ~tck_s[2];
  wire [2:0] next_ones = !tms_eff ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
  always_ff @(posedge mclk)
    tck_s <= {tck_s[1:0], jtag_in.tck};
  always_ff @(posedge mclk)
    if (rst)
      ones <= 3'h0;
    else if (tck_rise)
      ones <= next_ones;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_oe_hold;
    jtag_out.tdo_oe [*8];
  endsequence
  sequence s_tdo_hold;
    $stable(jtag_out.tdo) [*8];
  endsequence
  property p_leave_reset;
    $fell(rst) |-> tap_in_reset && !jtag_out.tdo_oe && !sram_outputs_hiz;
  endproperty
  property p_tdo_fall;
    $changed(jtag_out.tdo) |-> !jtag_in.tck && !$past(jtag_in.tck, 2);
  endproperty
  property p_oe_fall;
    $changed(jtag_out.tdo_oe) |-> !jtag_in.tck;
  endproperty
  property p_oe_hold;
    $rose(jtag_out.tdo_oe) |-> s_oe_hold;
  endproperty
  property p_tdo_hold;
    $changed(jtag_out.tdo) |=> s_tdo_hold;
  endproperty
  property p_quiet_in_reset;
    tap_in_reset |-> !jtag_out.tdo_oe;
  endproperty
  property p_hiz_reset;
    tap_in_reset [*3] |-> !sram_outputs_hiz;
  endproperty
  property p_five_ones;
    ones == 3'h5 && $past(ones) == 3'h4 |-> ##[0:6] tap_in_reset;
  endproperty
  a_leave_reset: assert property (p_leave_reset) else $error("bad state after reset");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved outside low clock");
  a_oe_fall: assert property (p_oe_fall) else $error("oe moved outside low clock");
  a_oe_hold: assert property (p_oe_hold) else $error("oe pulse too short");
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo not held");
  a_quiet_in_reset: assert property (p_quiet_in_reset) else $error("tdo driven in reset");
  a_hiz_reset: assert property (p_hiz_reset) else $error("outputs off in reset");
  a_five_ones: assert property (p_five_ones) else $error("no reset after five ones");
endmodule : sbt_tap_checker
bind sbt_tap sbt_tap_checker u_chk (.mclk(mclk), .rst(rst), .jtag_in(jtag_in), .jtag_tms_present(jtag_tms_present),
  .jtag_out(jtag_out), .sram_outputs_hiz(sram_outputs_hiz), .tap_in_reset(tap_in_reset));

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  import sbt_pkg::*;
  typedef struct {logic [2:0] code; int len; logic hiz;} sbt_row_t;
  localparam logic [127:0] PAT = 128'hC3A596F01E2D3B4C5A697887E1D2F00F;
  localparam logic [127:0] M110 = (128'h1 << 110) - 128'h1;
  logic mclk, rst, tms_on, tdi_on, hiz, in_rst, d;
  logic [SBT_BSR_W-1:0] ring;
  logic [127:0] so, cap;
  sbt_jtag_in_t jin;
  sbt_jtag_out_t jout;
  int bad_count, num_checks;
  sbt_row_t rows [5] = '{'{SBT_IR_ALLZERO, 107, 1'h0}, '{SBT_IR_IDCODE, 32, 1'h0}, '{SBT_IR_SAMPLE_Z, 107, 1'h1},
    '{SBT_IR_SAMPLE, 107, 1'h0}, '{SBT_IR_BYPASS, 1, 1'h0}};
  sbt_tap dut (.mclk(mclk), .rst(rst), .jtag_in(jin), .jtag_tms_present(tms_on), .jtag_tdi_present(tdi_on),
    .io_ring(ring), .jtag_out(jout), .sram_outputs_hiz(hiz), .tap_in_reset(in_rst));
  sbt_ctl_model ctl (.pins(jin), .tdo(jout.tdo));
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic go(input int k, input logic ms);
    repeat (k) ctl.step(ms, 1'h0, d);
  endtask : go
  // From idle: scan n bits of v through the IR or the selected DR
  task automatic scan(input logic ir, input int n, input logic [127:0] v);
    go(1 + ir, 1'h1);
    go(2, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      ctl.step(i == n - 1, v[i], d);
      if (i > 0)
        so[i - 1] = d;
      if (i == 1)
        chk("oe", 128'h1, {127'h0, jout.tdo_oe});
    end
    go(1, 1'h1);
    so[n - 1] = d;
    go(1, 1'h0);
    chk("oe_idle", 128'h0, {127'h0, jout.tdo_oe});
  endtask : scan
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #400000;
    bad_count++;
    close_out();
  end
  initial
  begin
    rst = 1'h1;
    tms_on = 1'h1;
    tdi_on = 1'h1;
    ring = PAT[106:0];
    repeat (8) @(posedge mclk);
    #1 rst = 1'h0;
    chk("reset", 128'h2, {126'h0, in_rst, hiz | jout.tdo_oe});
    go(1, 1'h0);
    foreach (rows[k])
    begin
      scan(1'h1, 3, {125'h0, rows[k].code});
      chk("ir_capture", 128'h1, {126'h0, so[1:0]});
      chk("hiz", {127'h0, rows[k].hiz}, {127'h0, hiz});
      ring = ~ring;
      cap = rows[k].len == 107 ? {21'h0, ring} : rows[k].len == 32 ? {96'h0, SBT_ID_VALUE} : 128'h0;
      scan(1'h0, 110, PAT);
      chk("dr", ((PAT << rows[k].len) | cap) & M110, so & M110);
    end
    tdi_on = 1'h0;
    scan(1'h0, 4, 128'h0);
    chk("pullup_tdi", 128'hE, {124'h0, so[3:0]});
    tdi_on = 1'h1;
    scan(1'h1, 3, {125'h0, SBT_IR_SAMPLE_Z});
    go(5, 1'h1);
    chk("tms_reset", 128'h2, {126'h0, in_rst, hiz});
    go(1, 1'h0);
    scan(1'h0, 32, 128'h0);
    chk("id_after_reset", {96'h0, SBT_ID_VALUE}, so & 128'hFFFFFFFF);
    tms_on = 1'h0;
    go(5, 1'h0);
    chk("pullup_tms", 128'h1, {127'h0, in_rst});
    close_out();
  end
endmodule : tb

// *** include/sbt_pkg.sv ***
package sbt_pkg;
  localparam int SBT_IR_W = 3;
  localparam int SBT_BSR_W = 107;
  localparam int SBT_ID_W = 32;
  localparam int SBT_RESET_TMS_COUNT = 5;
  localparam int SBT_FIFO_DEPTH = 4;
  localparam int SBT_FIFO_W = 1;
  localparam logic [2:0] SBT_IR_ALLZERO = 3'h0;
  localparam logic [2:0] SBT_IR_IDCODE = 3'h1;
  localparam logic [2:0] SBT_IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] SBT_IR_SAMPLE = 3'h4;
  localparam logic [2:0] SBT_IR_BYPASS = 3'h7;
  localparam logic [1:0] SBT_IR_CAPTURE = 2'h1;
  localparam logic SBT_BYPASS_RESET = 1'h0;
  // Identity fields: values are arbitrary
  localparam logic [3:0] SBT_ID_REVISION = 4'h0;
  localparam logic [15:0] SBT_ID_DEVICE = 16'h0000;
  localparam logic [10:0] SBT_ID_VENDOR = 11'h2AA;
  localparam logic SBT_ID_PRESENT = 1'h1;
  localparam logic [31:0] SBT_ID_VALUE = {SBT_ID_REVISION, SBT_ID_DEVICE, SBT_ID_VENDOR, SBT_ID_PRESENT};
  typedef enum logic [3:0] {
    SBT_RESET = 4'h0,
    SBT_IDLE = 4'h1,
    SBT_SEL_DR = 4'h3,
    SBT_CAP_DR = 4'h2,
    SBT_SHIFT_DR = 4'h6,
    SBT_EXIT1_DR = 4'h7,
    SBT_PAUSE_DR = 4'h5,
    SBT_EXIT2_DR = 4'h4,
    SBT_UPD_DR = 4'hC,
    SBT_SEL_IR = 4'hD,
    SBT_CAP_IR = 4'hF,
    SBT_SHIFT_IR = 4'hE,
    SBT_EXIT1_IR = 4'hA,
    SBT_PAUSE_IR = 4'hB,
    SBT_EXIT2_IR = 4'h9,
    SBT_UPD_IR = 4'h8
  } sbt_state_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_jtag_in_t;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sbt_jtag_out_t;
endpackage : sbt_pkg

// *** rtl/sbt_tap.sv ***
`timescale 1ns/1ns
// Contract
// - Sample TMS on rising TCK, pulled high
// - TDI shifts into selected register MSB
// - TDO shows LSB, changes on falling TCK
// - Five TMS-high edges reach reset state
// - Power-up reset leaves TDO high-impedance
// - Exactly one register selected by instruction
// - Three-bit IR, IDCODE after any reset
// - Capture-IR loads 01 into low bits
// - Bypass bit cleared under bypass instruction
// - Boundary register is 107 bits long
// - Capture-DR loads ring, Shift-DR shifts it
// - Zero, sample, sample-Z capture the ring
// - IDCODE capture loads hardwired 32-bit code
// - No drive or preload path to SRAM
// - All-zero acts as sample, outputs driven
// - Sample-Z forces SRAM outputs high-impedance
// - Update-DR under sample does nothing extra
// - Bypass instruction selects one-bit bypass
// - Instruction encodings as listed
// - ID: revision top, vendor 11:1, bit0 one

module sbt_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sbt_fifo

module sbt_tap
  import sbt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sbt_jtag_in_t jtag_in,
  input wire logic jtag_tms_present,
  input wire logic jtag_tdi_present,
  input wire logic [SBT_BSR_W-1:0] io_ring,
  output sbt_jtag_out_t jtag_out,
  output logic sram_outputs_hiz,
  output logic tap_in_reset
);
  // Pin synchronisers
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic tck_prev;
  sbt_state_t state;
  sbt_state_t next_state;
  logic [SBT_IR_W-1:0] ir_shift;
  logic [SBT_IR_W-1:0] ir;
  logic bypass_register;
  logic [SBT_BSR_W-1:0] boundary_scan_register;
  logic [SBT_ID_W-1:0] identification_register;
  logic [2:0] tms_high_count;
  logic tdo_oe_q;
  logic tdo_q;
  logic fifo_in_ready;
  logic fifo_out_data;
  logic fifo_out_valid;
  wire tms_raw = jtag_tms_present ? jtag_in.tms : 1'b1;
  wire tdi_raw = jtag_tdi_present ? jtag_in.tdi : 1'b1;
  always_ff @(posedge mclk)
  begin
    sync1 <= {jtag_in.tck, tms_raw, tdi_raw};
    sync2 <= sync1;
  end
  wire tck_s = sync2[2];
  wire tms_s = sync2[1];
  wire tdi_s = sync2[0];
  wire tck_rise = tck_s && !tck_prev;
  wire tck_fall = !tck_s && tck_prev;
  function automatic sbt_state_t sbt_next(input sbt_state_t s, input logic tms);
    case (s)
      SBT_RESET: sbt_next = tms ? SBT_RESET : SBT_IDLE;
      SBT_IDLE: sbt_next = tms ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_DR: sbt_next = tms ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_CAP_DR: sbt_next = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
      SBT_SHIFT_DR: sbt_next = tms ? SBT_EXIT1_DR : SBT_SHIFT_DR;
      SBT_EXIT1_DR: sbt_next = tms ? SBT_UPD_DR : SBT_PAUSE_DR;
      SBT_PAUSE_DR: sbt_next = tms ? SBT_EXIT2_DR : SBT_PAUSE_DR;
      SBT_EXIT2_DR: sbt_next = tms ? SBT_UPD_DR : SBT_SHIFT_DR;
      SBT_UPD_DR: sbt_next = tms ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_IR: sbt_next = tms ? SBT_RESET : SBT_CAP_IR;
      SBT_CAP_IR: sbt_next = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
      SBT_SHIFT_IR: sbt_next = tms ? SBT_EXIT1_IR : SBT_SHIFT_IR;
      SBT_EXIT1_IR: sbt_next = tms ? SBT_UPD_IR : SBT_PAUSE_IR;
      SBT_PAUSE_IR: sbt_next = tms ? SBT_EXIT2_IR : SBT_PAUSE_IR;
      SBT_EXIT2_IR: sbt_next = tms ? SBT_UPD_IR : SBT_SHIFT_IR;
      SBT_UPD_IR: sbt_next = tms ? SBT_SEL_DR : SBT_IDLE;
      default: sbt_next = SBT_RESET;
    endcase
  endfunction : sbt_next
  function automatic logic sbt_is_boundary(input logic [SBT_IR_W-1:0] code);
    sbt_is_boundary = (code == SBT_IR_ALLZERO) || (code == SBT_IR_SAMPLE) || (code == SBT_IR_SAMPLE_Z);
  endfunction : sbt_is_boundary
  // Five TMS-high edges force reset independent of state
  wire five_high = tms_s && (tms_high_count == 3'(SBT_RESET_TMS_COUNT - 1));
  assign next_state = five_high ? SBT_RESET : sbt_next(state, tms_s);
  wire sel_bsr = sbt_is_boundary(ir);
  wire sel_id = (ir == SBT_IR_IDCODE);
  wire sel_byp = !sel_bsr && !sel_id;
  wire in_shift_dr = (state == SBT_SHIFT_DR);
  wire in_shift_ir = (state == SBT_SHIFT_IR);
  wire dr_lsb = sel_bsr ? boundary_scan_register[0] : (sel_id ? identification_register[0] : bypass_register);
  wire shift_lsb = in_shift_ir ? ir_shift[0] : dr_lsb;
  // Serial output stream, buffered from rising-edge shift to falling-edge launch
  wire fifo_push = tck_rise && (in_shift_dr || in_shift_ir);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tck_prev <= 1'b0;
      state <= SBT_RESET;
      tms_high_count <= '0;
    end
    else
    begin
      tck_prev <= tck_s;
      if (tck_rise)
      begin
        state <= next_state;
        tms_high_count <= (!tms_s || five_high) ? 3'h0 : tms_high_count + 3'h1;
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ir_shift <= SBT_IR_IDCODE;
      ir <= SBT_IR_IDCODE;
      bypass_register <= SBT_BYPASS_RESET;
      boundary_scan_register <= '0;
      identification_register <= '0;
    end
    else if (tck_rise && fifo_in_ready)
    begin
      case (state)
        SBT_RESET: ir <= SBT_IR_IDCODE;
        SBT_CAP_IR: ir_shift <= {ir[SBT_IR_W-1], SBT_IR_CAPTURE};
        SBT_SHIFT_IR: ir_shift <= {tdi_s, ir_shift[SBT_IR_W-1:1]};
        SBT_UPD_IR: ir <= ir_shift;
        SBT_CAP_DR:
        begin
          if (sel_bsr)
            boundary_scan_register <= io_ring;
          if (sel_id)
            identification_register <= SBT_ID_VALUE;
          if (sel_byp)
            bypass_register <= SBT_BYPASS_RESET;
        end
        SBT_SHIFT_DR:
        begin
          if (sel_bsr)
            boundary_scan_register <= {tdi_s, boundary_scan_register[SBT_BSR_W-1:1]};
          if (sel_id)
            identification_register <= {tdi_s, identification_register[SBT_ID_W-1:1]};
          if (sel_byp)
            bypass_register <= tdi_s;
        end
        // Update-DR holds everything, no preload into I/O buffers
        SBT_UPD_DR: ir <= ir;
        default: ir <= ir;
      endcase
      // Load IDCODE on the edge that enters reset, so it holds while in reset
      if (next_state == SBT_RESET)
        ir <= SBT_IR_IDCODE;
    end
  end
  sbt_fifo #(
    .WIDTH(SBT_FIFO_W),
    .DEPTH(SBT_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_data(shift_lsb),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(tck_fall)
  );
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      sram_outputs_hiz <= 1'b0;
      tap_in_reset <= 1'b1;
    end
    else
    begin
      if (tck_fall)
      begin
        if (fifo_out_valid)
          tdo_q <= fifo_out_data;
        tdo_oe_q <= in_shift_dr || in_shift_ir;
      end
      sram_outputs_hiz <= (ir == SBT_IR_SAMPLE_Z);
      tap_in_reset <= (state == SBT_RESET);
    end
  end
  assign jtag_out.tdo = tdo_q;
  assign jtag_out.tdo_oe = tdo_oe_q;
endmodule : sbt_tap
